/* include/rsp_pkg.sv */
package rsp_pkg;
    // ----------------------------------------
    // pad sharing modes, pad kinds and self-test sequencer states
    // ----------------------------------------
    // how the stimulus pad is used
    typedef enum logic [1:0] {
        STIM_DEDICATED = 2'h0,
        STIM_SHARE_IN = 2'h1,
        STIM_SHARE_OUT = 2'h2
    } rsp_stim_mode_t;
    // how the result pads are used
    typedef enum logic [1:0] {
        RES_DEDICATED = 2'h0,
        RES_SHARE_IN = 2'h1,
        RES_SHARE_OUT = 2'h2
    } rsp_res_mode_t;
    // electrical kind of a pad
    typedef enum logic [1:0] {
        PAD_CMOS = 2'h0,
        PAD_OPEN_DRAIN = 2'h1,
        PAD_LOW_SWING = 2'h2,
        PAD_OV_TOLERANT = 2'h3
    } rsp_pad_kind_t;
    // self-test step sequencer
    typedef enum logic {
        ST_WRITE_NEXT = 1'h0,
        ST_READ_NEXT = 1'h1
    } rsp_bist_state_t;

    // ----------------------------------------
    // defaults and levels
    // ----------------------------------------
    localparam int RSP_NUM_RAMS = 2; // rams with own result pin
    localparam int RSP_BLK_WORDS = 16; // words per block
    localparam int RSP_BLK_BITS = 4; // bits per block
    localparam int RSP_ROWS = 2; // blocks stacked in depth
    localparam int RSP_COLS = 2; // blocks side by side
    localparam logic RSP_ENABLE_ACTIVE = 1'h0; // enable level meaning test
    localparam int RSP_CHECK_STEPS = 9; // connection check length
    localparam logic [8:0] RSP_CHECK_RESULT = 9'h044; // 001000100, step 0 first
endpackage

/* include/rsp_ram_if.sv */
`timescale 1ns/1ns
// ----------------------------------------
// pin side to self-test circuit of one ram
// ----------------------------------------
interface rsp_ram_if #(
    parameter int AW = 5,
    parameter int DW = 8
) ();
    logic testEnN; // common test enable, low = test
    logic stim; // common stimulus
    logic result; // own result of this ram
    logic [AW-1:0] funcAddr; // functional address
    logic [DW-1:0] funcWrData; // functional write data
    logic funcWe; // functional write strobe
    logic funcCs; // functional access strobe
    logic [DW-1:0] funcRdData; // registered read data

    modport pins (
        output testEnN, stim, funcAddr, funcWrData, funcWe, funcCs,
        input result, funcRdData
    );
    modport bist (
        input testEnN, stim, funcAddr, funcWrData, funcWe, funcCs,
        output result, funcRdData
    );
endinterface

/* src/rsp_bist.sv */
`timescale 1ns/1ns
// ----------------------------------------
// self-test circuit with its ram array
// ----------------------------------------
module rsp_bist #(
    parameter int BLK_WORDS = rsp_pkg::RSP_BLK_WORDS,
    parameter int BLK_BITS = rsp_pkg::RSP_BLK_BITS,
    parameter int ROWS = rsp_pkg::RSP_ROWS,
    parameter int COLS = rsp_pkg::RSP_COLS
) (
    input wire logic clk,
    input wire logic reset,
    rsp_ram_if.bist ram
);
    import rsp_pkg::*;

    localparam int RW = $clog2(BLK_WORDS); // in-block address bits
    localparam int SW = $clog2(ROWS); // block select bits
    localparam int AW = RW + SW;
    localparam int DW = BLK_BITS * COLS;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (BLK_WORDS < 2 || (1 << RW) != BLK_WORDS || ROWS < 2 || (1 << SW) != ROWS)
        $error("block words and rows must be powers of two, at least two");

    // expected data generator, used for writing and comparing
    function automatic logic [DW-1:0] patternOf(input logic [AW-1:0] a);
        logic [DW-1:0] d;
        d = '0;
        for (int i = 0; i < DW; i++) begin
            d[i] = a[i % AW] ^ i[0];
        end
        return d;
    endfunction

    rsp_bist_state_t state_r; // next step kind
    logic [AW-1:0] bistAddr_r; // test address
    logic [AW-1:0] cmpAddr_r; // address of pending compare
    logic cmpPend_r; // read data due for compare
    logic fail_r; // sticky mismatch
    logic [DW-1:0] rdData_r; // read register
    logic testOn; // enable at test level
    logic stepOn; // stimulus step taken
    logic bistWr; // test write step
    logic bistRd; // test read step
    logic [AW-1:0] memAddr;
    logic [DW-1:0] memWrData;
    logic memWe;
    logic memCs;
    logic [ROWS-1:0] rowCs; // per-row chip select
    wire [DW-1:0] rowWord [ROWS]; // asynchronous row read

    assign testOn = (ram.testEnN == RSP_ENABLE_ACTIVE);
    assign stepOn = testOn && ram.stim;
    assign bistWr = stepOn && (state_r == ST_WRITE_NEXT);
    assign bistRd = stepOn && (state_r == ST_READ_NEXT);

    // ----------------------------------------
    // access selector: test or functional
    // ----------------------------------------
    always_comb begin
        if (testOn) begin
            memAddr = bistAddr_r;
            memWrData = patternOf(bistAddr_r);
            memWe = bistWr;
            memCs = bistWr || bistRd;
        end else begin
            memAddr = ram.funcAddr;
            memWrData = ram.funcWrData;
            memWe = ram.funcWe;
            memCs = ram.funcCs;
        end
    end

    // ----------------------------------------
    // block array: rows by depth, columns by width
    // ----------------------------------------
    for (genvar r = 0; r < ROWS; r++) begin : gRow
        // upper address decodes the row
        assign rowCs[r] = memCs && (memAddr[AW-1:RW] == SW'(r));
        for (genvar c = 0; c < COLS; c++) begin : gCol
            logic [BLK_BITS-1:0] mem [BLK_WORDS]; // one block
            // write this block's slice
            always_ff @(posedge clk) begin
                if (rowCs[r] && memWe) begin
                    mem[memAddr[RW-1:0]] <= memWrData[c*BLK_BITS +: BLK_BITS];
                end
            end
            assign rowWord[r][c*BLK_BITS +: BLK_BITS] = mem[memAddr[RW-1:0]];
        end
    end

    // read register
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_r <= '0;
        end else if (memCs && !memWe) begin
            rdData_r <= rowWord[memAddr[AW-1:RW]];
        end
    end

    // ----------------------------------------
    // test sequencer: write, then read, per address
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset || !testOn) begin
            state_r <= ST_WRITE_NEXT;
            bistAddr_r <= '0;
        end else if (stepOn) begin
            case (state_r)
                ST_WRITE_NEXT: begin
                    state_r <= ST_READ_NEXT;
                end
                ST_READ_NEXT: begin
                    state_r <= ST_WRITE_NEXT;
                    bistAddr_r <= bistAddr_r + 1'b1;
                end
                default: begin
                    state_r <= ST_WRITE_NEXT;
                end
            endcase
        end
    end

    // compare bookkeeping
    always_ff @(posedge clk) begin
        if (reset || !testOn) begin
            cmpPend_r <= 1'h0;
            cmpAddr_r <= '0;
        end else begin
            cmpPend_r <= bistRd;
            if (bistRd) begin
                cmpAddr_r <= bistAddr_r;
            end
        end
    end

    // sticky fail, cleared when test ends
    always_ff @(posedge clk) begin
        if (reset || !testOn) begin
            fail_r <= 1'h0;
        end else if (cmpPend_r && rdData_r != patternOf(cmpAddr_r)) begin
            fail_r <= 1'h1;
        end
    end

    // pass pulse on each write step, no register from stimulus
    assign ram.result = bistWr && !fail_r;
    assign ram.funcRdData = rdData_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // connection check opening: enable high, then low with stimulus low
    sequence checkHead;
        (ram.testEnN && !ram.stim) ##1 (testOn && !ram.stim);
    endsequence
    sequence checkFirstPair;
        checkHead ##1 (testOn && ram.stim);
    endsequence

    chk_fail_latch:
        assert property (cmpPend_r && testOn && rdData_r != patternOf(cmpAddr_r)
            |=> fail_r || !testOn)
        else $error("mismatch did not latch fail");
    chk_fail_blocks:
        assert property (fail_r |-> !ram.result)
        else $error("result pulsed after a fail");
    chk_row_onehot:
        assert property (memCs |-> $onehot(rowCs))
        else $error("row chip select not one-hot");
    chk_check_pass:
        assert property (checkFirstPair |-> ram.result)
        else $error("check step two did not report one");
    chk_check_quiet:
        assert property (checkFirstPair ##1 (testOn && !ram.stim)
            ##1 (testOn && ram.stim) |-> !ram.result)
        else $error("check read step reported one");
    chk_check_head:
        assert property (ram.testEnN |-> !ram.result)
        else $error("result high outside test");
endmodule

/* src/rsp_pin_sharing.sv */
`timescale 1ns/1ns
module rsp_pin_sharing #(
    parameter int NUM_RAMS = rsp_pkg::RSP_NUM_RAMS,
    parameter int BLK_WORDS = rsp_pkg::RSP_BLK_WORDS,
    parameter int BLK_BITS = rsp_pkg::RSP_BLK_BITS,
    parameter int ROWS = rsp_pkg::RSP_ROWS,
    parameter int COLS = rsp_pkg::RSP_COLS,
    parameter rsp_pkg::rsp_stim_mode_t STIM_MODE = rsp_pkg::STIM_DEDICATED,
    parameter rsp_pkg::rsp_res_mode_t RES_MODE = rsp_pkg::RES_DEDICATED,
    parameter rsp_pkg::rsp_pad_kind_t STIM_PAD_KIND = rsp_pkg::PAD_CMOS,
    parameter rsp_pkg::rsp_pad_kind_t RES_PAD_KIND = rsp_pkg::PAD_CMOS,
    localparam int AW = $clog2(BLK_WORDS) + $clog2(ROWS),
    localparam int DW = BLK_BITS * COLS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic selftestEnableN,
    input wire logic stimPadIn,
    output logic stimPadOut,
    output logic stimPadOeN,
    input wire logic funcOutOnStim,
    output logic funcInFromStim,
    input wire logic [NUM_RAMS-1:0] resultPadIn,
    output logic [NUM_RAMS-1:0] resultPadOut,
    output logic [NUM_RAMS-1:0] resultPadOeN,
    input wire logic [NUM_RAMS-1:0] funcOutOnResult,
    output logic [NUM_RAMS-1:0] funcInFromResult,
    input wire logic [NUM_RAMS*AW-1:0] funcAddr,
    input wire logic [NUM_RAMS*DW-1:0] funcWrData,
    input wire logic [NUM_RAMS-1:0] funcWe,
    input wire logic [NUM_RAMS-1:0] funcCs,
    output logic [NUM_RAMS*DW-1:0] funcRdData
);
    import rsp_pkg::*;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (NUM_RAMS < 1)
        $error("at least one ram is needed");
    // special pads cannot turn around or swing fully
    if (STIM_MODE != STIM_DEDICATED && STIM_PAD_KIND != PAD_CMOS)
        $error("stimulus pad kind cannot be shared");
    if (RES_MODE != RES_DEDICATED && RES_PAD_KIND != PAD_CMOS)
        $error("result pad kind cannot be shared");

    logic [NUM_RAMS-1:0] bistResult; // one result per ram
    logic testMode; // enable at test level
    logic stimToBist; // common stimulus
    logic stimSync_r; // first sync stage
    logic funcInFromStim_r;
    logic [NUM_RAMS-1:0] resSync_r; // first sync stages
    logic [NUM_RAMS-1:0] funcInFromResult_r;

    assign testMode = (selftestEnableN == RSP_ENABLE_ACTIVE);
    // straight wire from pad, no gate or flop in between
    assign stimToBist = stimPadIn;

    // ----------------------------------------
    // self-test circuits, one per ram
    // ----------------------------------------
    rsp_ram_if #(.AW(AW), .DW(DW)) ramIf [NUM_RAMS] ();

    for (genvar g = 0; g < NUM_RAMS; g++) begin : gRam
        // dedicated enable pin fans out to every ram
        assign ramIf[g].testEnN = selftestEnableN;
        assign ramIf[g].stim = stimToBist;
        assign ramIf[g].funcAddr = funcAddr[g*AW +: AW];
        assign ramIf[g].funcWrData = funcWrData[g*DW +: DW];
        assign ramIf[g].funcWe = funcWe[g];
        assign ramIf[g].funcCs = funcCs[g];
        // results kept apart, never merged
        assign bistResult[g] = ramIf[g].result;
        assign funcRdData[g*DW +: DW] = ramIf[g].funcRdData;

        rsp_bist #(
            .BLK_WORDS(BLK_WORDS),
            .BLK_BITS(BLK_BITS),
            .ROWS(ROWS),
            .COLS(COLS)
        ) uBist (
            .clk(clk),
            .reset(reset),
            .ram(ramIf[g])
        );
    end

    // ----------------------------------------
    // stimulus pad
    // ----------------------------------------
    // shared output drives only in normal mode; tester leaves it low at end
    always_comb begin
        case (STIM_MODE)
            STIM_SHARE_OUT: begin
                stimPadOut = funcOutOnStim;
                stimPadOeN = testMode;
            end
            default: begin
                stimPadOut = 1'h0;
                stimPadOeN = 1'h1; // input only
            end
        endcase
    end

    // ----------------------------------------
    // result pads
    // ----------------------------------------
    // per-ram pad, driven without any register
    always_comb begin
        case (RES_MODE)
            RES_SHARE_IN: begin
                resultPadOut = bistResult;
                resultPadOeN = {NUM_RAMS{selftestEnableN}};
            end
            RES_SHARE_OUT: begin
                // selector in front of the pad
                resultPadOut = testMode ? bistResult : funcOutOnResult;
                resultPadOeN = '0;
            end
            default: begin
                resultPadOut = bistResult;
                resultPadOeN = '0;
            end
        endcase
    end

    // ----------------------------------------
    // functional inputs from shared pads
    // ----------------------------------------
    // two-stage sync of the stimulus pad for functional logic
    always_ff @(posedge clk) begin
        if (reset) begin
            stimSync_r <= 1'h0;
            funcInFromStim_r <= 1'h0;
        end else begin
            stimSync_r <= stimPadIn;
            funcInFromStim_r <= (STIM_MODE == STIM_SHARE_IN) ? stimSync_r : 1'h0;
        end
    end

    // two-stage sync of result pads used as inputs
    always_ff @(posedge clk) begin
        if (reset) begin
            resSync_r <= '0;
            funcInFromResult_r <= '0;
        end else begin
            resSync_r <= resultPadIn;
            funcInFromResult_r <= (RES_MODE == RES_SHARE_IN) ? resSync_r : '0;
        end
    end

    assign funcInFromStim = funcInFromStim_r;
    assign funcInFromResult = funcInFromResult_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_result_route:
        assert property (testMode |-> resultPadOut == bistResult)
        else $error("result pad not showing own result in test");
    chk_common_feed:
        assert property (ramIf[0].testEnN == selftestEnableN
            && ramIf[NUM_RAMS-1].stim == stimPadIn)
        else $error("enable or stimulus not common");
    chk_stim_release:
        assert property (testMode |-> stimPadOeN)
        else $error("stimulus pad driven during test");
    chk_stim_drive:
        assert property (STIM_MODE == STIM_SHARE_OUT && !testMode
            |-> !stimPadOeN && stimPadOut == funcOutOnStim)
        else $error("shared stimulus output not driven");
    chk_stim_func_in:
        assert property (STIM_MODE == STIM_SHARE_IN
            |=> ##1 funcInFromStim_r == $past(stimPadIn, 2))
        else $error("stimulus pad not reaching functional input");
    chk_res_turn:
        assert property (RES_MODE == RES_SHARE_IN && !testMode |-> &resultPadOeN)
        else $error("shared result pad driven in normal mode");
    chk_res_select:
        assert property (RES_MODE == RES_SHARE_OUT && !testMode
            |-> resultPadOut == funcOutOnResult)
        else $error("selector not passing functional output");
    chk_res_stable:
        assert property (testMode && $stable(bistResult) && $stable(testMode)
            |-> $stable(resultPadOut))
        else $error("result pad changed without its cause");
    // pads that are never turned around keep one fixed direction
    // a pad without a functional input feeds nothing to the functional logic
    chk_stim_in_only:
        assert property (STIM_MODE != STIM_SHARE_OUT |-> stimPadOeN && !stimPadOut)
        else $error("unshared stimulus pad driven");
    chk_res_drive_test:
        assert property (RES_MODE == RES_SHARE_IN && testMode |-> resultPadOeN == '0)
        else $error("shared result pad released in test");
    chk_res_always_drive:
        assert property (RES_MODE != RES_SHARE_IN |-> resultPadOeN == '0)
        else $error("result pad released outside shared input");
    chk_res_func_quiet:
        assert property (RES_MODE != RES_SHARE_IN |-> funcInFromResult_r == '0)
        else $error("functional input seen on unshared result pad");
endmodule

/* verif/rsp_tester_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// tester model: drives enable and stimulus pads
// ----------------------------------------
module rsp_tester_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] nSteps,
    input wire logic idleStim,
    output logic testEnN,
    output logic stim,
    output logic [7:0] step,
    output logic busy
);
    // board holds enable at its non-test level until a check starts
    initial begin
        testEnN = 1'h1;
        stim = 1'h0;
        step = 8'h00;
        busy = 1'h0;
    end

    // ----------------------------------------
    // pattern stepper, one step per falling edge
    // ----------------------------------------
    always @(negedge clk) begin
        if (!busy && start) begin
            // first step: enable high, functional pattern ended low
            busy <= 1'h1;
            step <= 8'h00;
            testEnN <= 1'h1;
            stim <= 1'h0;
        end else if (busy && (step + 8'h01 == nSteps)) begin
            // pattern over: back to normal level
            busy <= 1'h0;
            testEnN <= 1'h1;
            stim <= 1'h0;
        end else if (busy) begin
            // enable low, stimulus alternates zero then one
            step <= step + 8'h01;
            testEnN <= 1'h0;
            stim <= step[0];
        end else begin
            // functional use of the stimulus pad
            stim <= idleStim;
        end
    end
endmodule

/* verif/tb_ram_selftest_pin_sharing.sv */
`timescale 1ns/1ns
module tb_ram_selftest_pin_sharing;
    import rsp_pkg::*;
    // ----------------------------------------
    // sizes and signals
    // ----------------------------------------
    localparam int NR = RSP_NUM_RAMS; // rams in the design
    localparam int AWD = $clog2(RSP_BLK_WORDS) + $clog2(RSP_ROWS); // address width
    localparam int DWD = RSP_BLK_BITS * RSP_COLS; // word width
    logic clk, reset, start, idleStim, testEnN, tstStim, busy;
    logic [7:0] nSteps, step;
    logic funcOutOnStim;
    logic [NR-1:0] benchResIn, funcOutOnResult, funcWe, funcCs;
    logic [NR*AWD-1:0] funcAddr;
    logic [NR*DWD-1:0] funcWrData, aRdData, bRdData;
    logic aStimOut, aStimOeN, aFuncInStim, bStimOut, bStimOeN, bFuncInStim;
    logic [NR-1:0] aResOut, aResOeN, aFuncInRes, bResOut, bResOeN, bFuncInRes;
    logic cStimOeN, cFuncInStim; // dedicated-pad copy
    logic [NR-1:0] cResOut, cResOeN, cFuncInRes;
    logic [NR*DWD-1:0] cRdData;
    int nErrors, cmpCount;
    // resolved pad levels from all drivers
    wire aStimPad = aStimOeN ? tstStim : aStimOut;
    wire [NR-1:0] bResPad = (bResOeN & benchResIn) | (~bResOeN & bResOut);

    // ----------------------------------------
    // design copies: output-shared, input-shared and dedicated pads
    // ----------------------------------------
    rsp_pin_sharing #(.STIM_MODE(STIM_SHARE_OUT), .RES_MODE(RES_SHARE_OUT)) rsp_pin_sharing_i (
        .clk(clk), .reset(reset), .selftestEnableN(testEnN), .stimPadIn(aStimPad),
        .stimPadOut(aStimOut), .stimPadOeN(aStimOeN), .funcOutOnStim(funcOutOnStim),
        .funcInFromStim(aFuncInStim), .resultPadIn(benchResIn), .resultPadOut(aResOut),
        .resultPadOeN(aResOeN), .funcOutOnResult(funcOutOnResult),
        .funcInFromResult(aFuncInRes), .funcAddr(funcAddr), .funcWrData(funcWrData),
        .funcWe(funcWe), .funcCs(funcCs), .funcRdData(aRdData));
    rsp_pin_sharing #(.STIM_MODE(STIM_SHARE_IN), .RES_MODE(RES_SHARE_IN)) rsp_pin_sharing_b_i (
        .clk(clk), .reset(reset), .selftestEnableN(testEnN), .stimPadIn(tstStim),
        .stimPadOut(bStimOut), .stimPadOeN(bStimOeN), .funcOutOnStim(funcOutOnStim),
        .funcInFromStim(bFuncInStim), .resultPadIn(bResPad), .resultPadOut(bResOut),
        .resultPadOeN(bResOeN), .funcOutOnResult(funcOutOnResult),
        .funcInFromResult(bFuncInRes), .funcAddr(funcAddr), .funcWrData(funcWrData),
        .funcWe(funcWe), .funcCs(funcCs), .funcRdData(bRdData));
    rsp_pin_sharing rsp_pin_sharing_c_i (
        .clk(clk), .reset(reset), .selftestEnableN(testEnN), .stimPadIn(tstStim),
        .stimPadOut(), .stimPadOeN(cStimOeN), .funcOutOnStim(funcOutOnStim),
        .funcInFromStim(cFuncInStim), .resultPadIn(benchResIn), .resultPadOut(cResOut),
        .resultPadOeN(cResOeN), .funcOutOnResult(funcOutOnResult),
        .funcInFromResult(cFuncInRes), .funcAddr(funcAddr), .funcWrData(funcWrData),
        .funcWe(funcWe), .funcCs(funcCs), .funcRdData(cRdData));
    rsp_tester_model rsp_tester_model_i (
        .clk(clk), .start(start), .nSteps(nSteps), .idleStim(idleStim),
        .testEnN(testEnN), .stim(tstStim), .step(step), .busy(busy));

    // ----------------------------------------
    // clock and shared helpers
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic giveVerdict;
        $display("counts: %0d compares, %0d mismatches", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // functional word pattern, distinct per ram
    function automatic logic [NR*DWD-1:0] wdat(input logic [AWD-1:0] a);
        return {8'h5a + {3'h0, a}, 8'ha5 ^ {3'h0, a}};
    endfunction

    // one functional access to both rams
    task automatic ramAccess(input logic [AWD-1:0] a, input logic we);
        @(negedge clk);
        funcAddr = {NR{a}};
        funcWrData = wdat(a);
        funcWe = {NR{we}};
        funcCs = '1;
        @(negedge clk);
        funcCs = '0;
        funcWe = '0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // normal mode: output-shared pads pass functional signals at once
    task automatic tNormalPaths;
        for (int v = 0; v < 2; v++) begin
            @(negedge clk);
            funcOutOnStim = v[0];
            funcOutOnResult = NR'(v + 1);
            #1;
            chk(aStimOeN, 1'h0);
            chk(aStimOut, v[0]);
            chk(aResOut, funcOutOnResult);
            chk(aResOeN, '0);
            chk(bResOeN, {NR{1'h1}});
            chk(bStimOeN, 1'h1);
            chk(cResOut, '0);
            chk(cStimOeN, 1'h1);
        end
        $display("test normal paths finished");
    endtask

    // functional inputs read through shared pads, two edges late
    task automatic tSharedInputs;
        @(posedge clk);
        idleStim <= 1'h1;
        @(negedge clk);
        benchResIn = 2'h2;
        @(negedge clk);
        #1;
        chk(bFuncInStim, 1'h0);
        chk(bFuncInRes, '0);
        @(negedge clk);
        #1;
        chk(bFuncInStim, 1'h1);
        chk(bFuncInRes, 2'h2);
        chk({aFuncInStim, aFuncInRes}, '0);
        chk({cFuncInStim, cFuncInRes}, '0);
        benchResIn = '0;
        @(posedge clk);
        idleStim <= 1'h0;
        $display("test shared inputs finished");
    endtask

    // words written then read across both block rows
    task automatic tFuncRam;
        logic [AWD-1:0] addrs [4];
        addrs = '{5'h00, 5'h0f, 5'h10, 5'h1f};
        foreach (addrs[i]) ramAccess(addrs[i], 1'h1);
        foreach (addrs[i]) begin
            ramAccess(addrs[i], 1'h0);
            chk(aRdData, wdat(addrs[i]));
            chk(bRdData, wdat(addrs[i]));
            chk(cRdData, wdat(addrs[i]));
        end
        $display("test functional ram finished");
    endtask

    // tester pattern of n steps, result checked at every step
    task automatic tSelftest(input int n);
        int seen;
        logic exp;
        seen = 0;
        @(negedge clk);
        funcOutOnResult = '0;
        // functional pattern leaves the shared stimulus output low
        funcOutOnStim = 1'h0;
        nSteps = 8'(n);
        @(posedge clk);
        start <= 1'h1;
        for (int i = 0; i < n + 4; i++) begin
            @(negedge clk);
            #2;
            start = 1'h0;
            if (!busy) break;
            // connection check steps from the constant, later steps keep its rhythm
            exp = (step < RSP_CHECK_STEPS) ? RSP_CHECK_RESULT[step]
                : (!step[0] && (((step - 2) / 2) % 2 == 0));
            chk(aResOut, {NR{exp}});
            chk(bResOut, {NR{exp}});
            chk(aStimOeN, step != 0);
            chk(bResOeN, (step != 0) ? '0 : {NR{1'h1}});
            chk(cResOut, {NR{exp}});
            chk(cResOeN, '0);
            chk(cStimOeN, 1'h1);
            seen++;
        end
        chk(seen, n);
        $display("test self-test of %0d steps finished", n);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset = 1'h1;
        start = 1'h0;
        idleStim = 1'h0;
        nSteps = 8'h09;
        funcOutOnStim = 1'h0;
        benchResIn = '0;
        funcOutOnResult = '0;
        funcWe = '0;
        funcCs = '0;
        funcAddr = '0;
        funcWrData = '0;
        nErrors = 0;
        cmpCount = 0;
        repeat (5) @(negedge clk);
        reset = 1'h0;
        tNormalPaths();
        tSharedInputs();
        tFuncRam();
        tSelftest(RSP_CHECK_STEPS);
        tSelftest(137);
        tNormalPaths();
        giveVerdict();
    end
endmodule
